// ### inc/bus_retry_pkg.sv
// Purpose: shared constants and types for the bus retry and ordering logic
// Assumes: one bus clock, synchronous active-low reset
// Notes:   queue depth must be a power of two, at least two
`default_nettype none

package bus_retry_pkg;

    localparam int ADDR_W_DEF   = 32;
    localparam int DATA_W_DEF   = 32;
    localparam int WQ_DEPTH_DEF = 4;

    // four longwords per line
    localparam int LINE_BEATS = 4;
    localparam int BEAT_W     = 2;
    localparam logic [BEAT_W-1:0] BEAT_FIRST = 2'h0;
    localparam logic [BEAT_W-1:0] BEAT_LAST  = 2'h3;

    // address bits below this select a longword inside a line
    localparam int LINE_LSB = 4;

    localparam int PST_W = 4;
    localparam logic [PST_W-1:0] PST_RUN          = 4'h0;
    localparam logic [PST_W-1:0] PST_DOUBLE_FAULT = 4'h5;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ARB,
        ST_CYCLE,
        ST_HALT
    } busState_t;

endpackage

`default_nettype wire

// ### test/bus_partner_model.sv
// Purpose: far-side slave and grant source for the bus retry block
// Assumes: termination is given from the cycle after the start pulse
// Notes:   released data lines carry the inverse of their last value
`default_nettype none
module bus_partner_model
    import bus_retry_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        arm,
    input  wire logic        grantOn,
    input  wire logic        slow,
    input  wire logic [3:0]  retryCnt,
    input  wire logic [3:0]  errAt,
    input  wire logic        errIsRetry,
    input  wire logic        dropGrant,
    input  wire logic        transferStart_n,
    input  wire logic        busOe_n,
    input  wire logic [31:0] busAddr,
    output logic             transferAck_n,
    output logic             transferFaultAck_n,
    output logic             grantIn_n,
    output logic [31:0]      busDataIn
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0]  n;
    logic        waitPh;
    logic        answer;
    logic        retry;
    logic        fault;
    logic [31:0] last;
    // grant is held or withdrawn by the bench, and dropped on a retry answer when dropGrant is set, no arbitration here
    assign grantIn_n = !grantOn || (dropGrant && answer && retry);
    // slow mode puts one wait cycle before every answer
    assign answer = !busOe_n && transferStart_n && (!slow || waitPh);
    assign retry = (n < retryCnt) || (n == errAt && errIsRetry);
    assign fault = !retry && n == errAt;
    // both pins come from one state so they move on the same edge
    assign transferAck_n = !(answer && !fault);
    assign transferFaultAck_n = !(answer && (retry || fault));
    assign busDataIn = (answer && !retry && !fault) ? busAddr ^ 32'ha5a5_0000 : ~last;
    always_ff @(posedge clk) begin
        n <= arm ? 4'h0 : n + 4'(answer);
        waitPh <= !answer && !busOe_n && transferStart_n;
        last <= busDataIn;
    end
endmodule // bus_partner_model
`default_nettype wire

// ### test/bus_retry_fault_ordering_tb.sv
// Purpose: self-checking bench for retry, double fault and ordering
// Assumes: partner answers from the cycle after each start pulse
// Notes:   each scenario arms the partner with its termination script
`default_nettype none
module bus_retry_fault_ordering_tb
    import bus_retry_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, reset_n, rdValid, rdSerial, rdLine, rdBurstOff, rdLock, rdCancel, rdReady;
    logic rdDone, rdFault, wrValid, wrPush, wrLockLast, wrHit, cacheOn, wrReady, wrDone;
    logic wrFault, cacheWe, snoopInval, excStacking, addrErr, syncReq, syncStall;
    logic transferAck_n, transferFaultAck_n, grantIn_n, requestOut_n, transferStart_n;
    logic busWrite, busLine, lockOut_n, atomicFinalWriteFlag_n, busOe_n;
    logic [31:0] rdAddr, rdData, wrAddr, wrData, cacheAddr, cacheData, busAddr, busDataOut;
    logic [31:0] busDataIn, lastRd;
    logic [PST_W-1:0] procStateCode;
    logic grantOn, slow, errIsRetry, arm, firstWr, dropGrant;
    logic [3:0] retryCnt, errAt;
    int errors, compares, starts, dones, faults, cycles, wdones;
    bus_retry_fault_ordering uut (.clk(clk), .reset_n(reset_n), .rdValid(rdValid),
        .rdAddr(rdAddr), .rdSerial(rdSerial), .rdLine(rdLine), .rdBurstOff(rdBurstOff),
        .rdLock(rdLock), .rdCancel(rdCancel), .rdReady(rdReady), .rdDone(rdDone),
        .rdFault(rdFault), .rdData(rdData), .wrValid(wrValid), .wrAddr(wrAddr),
        .wrData(wrData), .wrPush(wrPush), .wrLockLast(wrLockLast), .wrHit(wrHit),
        .cacheOn(cacheOn), .wrReady(wrReady), .wrDone(wrDone), .wrFault(wrFault),
        .cacheWe(cacheWe), .cacheAddr(cacheAddr), .cacheData(cacheData),
        .snoopInval(snoopInval), .excStacking(excStacking), .addrErr(addrErr),
        .syncReq(syncReq), .syncStall(syncStall), .transferAck_n(transferAck_n),
        .transferFaultAck_n(transferFaultAck_n), .grantIn_n(grantIn_n),
        .requestOut_n(requestOut_n), .transferStart_n(transferStart_n), .busAddr(busAddr),
        .busWrite(busWrite), .busLine(busLine), .busDataOut(busDataOut),
        .busDataIn(busDataIn), .lockOut_n(lockOut_n),
        .atomicFinalWriteFlag_n(atomicFinalWriteFlag_n), .busOe_n(busOe_n),
        .procStateCode(procStateCode));
    bus_partner_model partner (.clk(clk), .arm(arm), .grantOn(grantOn), .slow(slow),
        .retryCnt(retryCnt), .errAt(errAt), .errIsRetry(errIsRetry), .dropGrant(dropGrant),
        .transferStart_n(transferStart_n), .busOe_n(busOe_n), .busAddr(busAddr),
        .transferAck_n(transferAck_n), .transferFaultAck_n(transferFaultAck_n),
        .grantIn_n(grantIn_n), .busDataIn(busDataIn));
    initial begin
        clk = 0;
        forever #20 clk = ~clk;
    end
    task automatic stop_test;
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    always @(posedge clk) begin
        if (transferStart_n === 1'b0) begin
            if (starts == 0) firstWr = busWrite;
            starts++;
            if (busWrite === 1'b0) check(busAddr, rdAddr);
            else begin
                check(busDataOut, wrData);
                check(32'(atomicFinalWriteFlag_n), 32'(!wrLockLast));
            end
        end
        if (rdDone === 1'b1) begin
            dones++;
            lastRd = rdData;
        end
        if (rdFault === 1'b1) faults++;
        if (wrDone === 1'b1) wdones++;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 6000) begin
            errors++;
            stop_test();
        end
    end
    task automatic setup(input logic [3:0] r, input logic [3:0] e, input logic er, input logic s);
        @(negedge clk);
        {retryCnt, errAt, errIsRetry, slow, arm} = {r, e, er, s, 1'b1};
        {starts, dones, faults, wdones} = '0;
        @(negedge clk);
        arm = 0;
    endtask
    task automatic rd(input logic [31:0] a, input logic ln, input logic ser);
        int k;
        @(negedge clk);
        {rdAddr, rdLine, rdSerial, rdValid} = {a, ln, ser, 1'b1};
        @(negedge clk);
        rdValid = 0;
        if (!grantOn) begin
            repeat (4) @(negedge clk);
            check(32'(starts), 32'h0);
            check(32'(requestOut_n), 32'h0);
            grantOn = 1;
        end
        for (k = 0; k < 60 && rdReady !== 1'b1; k++) @(negedge clk);
        repeat (3) @(negedge clk);
    endtask
    task automatic t_retry;
        setup(4'h3, 4'hf, 1'b0, 1'b1);
        excStacking = 1;
        rd(32'h240, 1'b0, 1'b0);
        excStacking = 0;
        check(32'(starts), 32'h4);
        check(32'(dones), 32'h1);
        check(lastRd, 32'h240 ^ 32'ha5a5_0000);
        check(32'(procStateCode), 32'(PST_RUN));
    endtask
    task automatic t_line;
        for (int b = 0; b < 2; b++) begin
            setup(4'h0, 4'h1, 1'b1, 1'b0);
            rdBurstOff = 1'(b);
            rd(32'h300, 1'b1, 1'b0);
            check(32'(dones), 32'h1);
            check(32'(faults), 32'h1);
        end
        rdBurstOff = 0;
    endtask
    task automatic t_serial;
        {wrHit, cacheOn, syncReq} = 3'b111;
        for (int s = 0; s < 3; s++) begin
            setup(4'h0, 4'hf, 1'b0, 1'b0);
            grantOn = 0;
            fork
                rd(s == 2 ? 32'h404 : 32'h800, 1'b0, 1'(s == 1));
                begin
                    @(negedge clk);
                    {wrAddr, wrData, wrValid} = {32'h400, 32'h1234_5678, 1'b1};
                    @(negedge clk);
                    wrValid = 0;
                    check(cacheAddr, 32'h400);
                    check(32'({cacheWe, syncStall}), 32'h3);
                end
            join
            repeat (2) @(negedge clk);
            check(32'(firstWr), 32'(s != 0));
            check(32'(dones), 32'h1);
            check(32'(wdones), 32'h1);
            check(32'(syncStall), 32'h0);
        end
        syncReq = 0;
    endtask
    task automatic t_lock;
        setup(4'h1, 4'h2, 1'b1, 1'b0);
        {rdLock, dropGrant} = 2'b11;
        rd(32'h600, 1'b0, 1'b0);
        check(32'({starts[3:0], lockOut_n}), 32'h4);
        {rdLock, wrData, wrLockLast, wrValid} = {1'b0, 32'h77, 2'b11};
        @(negedge clk);
        wrValid = 0;
        repeat (12) @(negedge clk);
        check(32'({wdones[3:0], lockOut_n}), 32'h3);
        {wrLockLast, dropGrant} = 2'b00;
    endtask
    task automatic t_fault;
        setup(4'h0, 4'h0, 1'b0, 1'b0);
        rd(32'h500, 1'b0, 1'b0);
        check(32'(faults), 32'h1);
        check(32'(procStateCode), 32'(PST_RUN));
        setup(4'h0, 4'h0, 1'b0, 1'b0);
        excStacking = 1;
        rd(32'h504, 1'b0, 1'b0);
        repeat (20) @(negedge clk);
        check(32'(procStateCode), 32'(PST_DOUBLE_FAULT));
        check(32'({requestOut_n, busOe_n}), 32'h3);
        {excStacking, reset_n} = 2'b00;
        repeat (2) @(negedge clk);
        reset_n = 1;
        @(negedge clk);
        check(32'(procStateCode), 32'(PST_RUN));
    endtask
    initial begin
        {reset_n, rdValid, rdSerial, rdLine, rdBurstOff, rdLock, rdCancel} = '0;
        {wrValid, wrPush, wrLockLast, wrHit, cacheOn, snoopInval, excStacking} = '0;
        {addrErr, syncReq, slow, errIsRetry, retryCnt, errAt} = '0;
        {rdAddr, wrAddr, wrData} = '0;
        {grantOn, arm, dropGrant} = 3'b110;
        {errors, compares, starts, dones, faults, cycles} = '0;
        repeat (12) @(negedge clk);
        reset_n = 1;
        setup(4'h0, 4'hf, 1'b0, 1'b0);
        rd(32'h100, 1'b0, 1'b0);
        check(lastRd, 32'h100 ^ 32'ha5a5_0000);
        t_retry();
        t_line();
        t_serial();
        t_lock();
        t_fault();
        stop_test();
    end
endmodule // bus_retry_fault_ordering_tb
`default_nettype wire

// ### verilog/_unused_placeholder_never.sv
`default_nettype none
`default_nettype wire

// ### verilog/bus_retry_fault_ordering.sv
// Purpose: bus cycle sequencing with retry, double fault halt and ordering
// Assumes: termination and grant pins are synchronous to clk
// Notes:   one read held at a time, writes queued in order
`default_nettype none

module bus_retry_fault_ordering
    import bus_retry_pkg::*;
#(
    parameter int ADDR_W   = ADDR_W_DEF,
    parameter int DATA_W   = DATA_W_DEF,
    parameter int WQ_DEPTH = WQ_DEPTH_DEF
) (
    input  wire logic              clk,
    input  wire logic              reset_n,
    input  wire logic              rdValid,
    input  wire logic [ADDR_W-1:0] rdAddr,
    input  wire logic              rdSerial,
    input  wire logic              rdLine,
    input  wire logic              rdBurstOff,
    input  wire logic              rdLock,
    input  wire logic              rdCancel,
    output logic                   rdReady,
    output logic                   rdDone,
    output logic                   rdFault,
    output logic [DATA_W-1:0]      rdData,
    input  wire logic              wrValid,
    input  wire logic [ADDR_W-1:0] wrAddr,
    input  wire logic [DATA_W-1:0] wrData,
    input  wire logic              wrPush,
    input  wire logic              wrLockLast,
    input  wire logic              wrHit,
    input  wire logic              cacheOn,
    output logic                   wrReady,
    output logic                   wrDone,
    output logic                   wrFault,
    output logic                   cacheWe,
    output logic [ADDR_W-1:0]      cacheAddr,
    output logic [DATA_W-1:0]      cacheData,
    input  wire logic              snoopInval,
    input  wire logic              excStacking,
    input  wire logic              addrErr,
    input  wire logic              syncReq,
    output logic                   syncStall,
    input  wire logic              transferAck_n,
    input  wire logic              transferFaultAck_n,
    input  wire logic              grantIn_n,
    output logic                   requestOut_n,
    output logic                   transferStart_n,
    output logic [ADDR_W-1:0]      busAddr,
    output logic                   busWrite,
    output logic                   busLine,
    output logic [DATA_W-1:0]      busDataOut,
    input  wire logic [DATA_W-1:0] busDataIn,
    output logic                   lockOut_n,
    output logic                   atomicFinalWriteFlag_n,
    output logic                   busOe_n,
    output logic [PST_W-1:0]       procStateCode
);

    localparam int PTR_W = $clog2(WQ_DEPTH);
    localparam int CNT_W = PTR_W + 1;

    busState_t         state_q;
    logic              startPulse_q;
    logic [BEAT_W-1:0] beat_q;
    logic              retried_q;
    logic [ADDR_W-1:0] curAddr_q;
    logic [DATA_W-1:0] curData_q;
    logic              curWrite_q;
    logic              curLine_q;
    logic              curBurstOff_q;
    logic              curLock_q;
    logic              curLast_q;
    logic              curPush_q;
    logic              curSerial_q;
    logic              lockOn_q;

    logic              rdPend_q;
    logic [ADDR_W-1:0] rdAddr_q;
    logic              rdSerial_q;
    logic              rdLine_q;
    logic              rdBurstOff_q;
    logic              rdLock_q;
    logic              rdDiscard_q;
    logic              rdDone_q;
    logic              rdFault_q;
    logic [DATA_W-1:0] rdData_q;

    logic [ADDR_W-1:0] wqAddr [WQ_DEPTH];
    logic [DATA_W-1:0] wqData [WQ_DEPTH];
    logic              wqPush [WQ_DEPTH];
    logic              wqLast [WQ_DEPTH];
    logic [PTR_W-1:0]  head_q;
    logic [PTR_W-1:0]  tail_q;
    logic [CNT_W-1:0]  count_q;
    logic              wrDone_q;
    logic              wrFault_q;
    logic              cacheWe_q;
    logic [ADDR_W-1:0] cacheAddr_q;
    logic [DATA_W-1:0] cacheData_q;

    logic              tOk;
    logic              tErr;
    logic              tRty;
    logic              termLive;
    logic              ok;
    logic              rty0;
    logic              errEff;
    logic              cycleDone;
    logic              doubleFault;
    logic              grant;
    logic              pushDrop;
    logic [WQ_DEPTH-1:0] hitVec;
    logic              readGo;
    logic              pickRead;
    logic              pickWrite;
    logic              rdAccept;
    logic              rdFinish;
    logic              rdStarted;
    logic              wrAccept;
    logic              wrPop;

    function automatic logic entryLive(input logic [PTR_W-1:0] idx,
                                       input logic [PTR_W-1:0] head,
                                       input logic [CNT_W-1:0] cnt);
        logic [PTR_W-1:0] off;
        off = idx - head;
        return {1'b0, off} < cnt;
    endfunction

    term_decode u_term (
        .transferAck_n      (transferAck_n),
        .transferFaultAck_n (transferFaultAck_n),
        .termOk             (tOk),
        .termErr            (tErr),
        .termRetry          (tRty)
    );

    // the start cycle itself is never taken as terminated
    assign termLive = (state_q == ST_CYCLE) && !startPulse_q;
    assign ok       = termLive && tOk;
    assign rty0     = termLive && tRty && (beat_q == BEAT_FIRST);
    assign errEff   = termLive && (tErr || (tRty && beat_q != BEAT_FIRST));
    assign cycleDone = (ok && (!curLine_q || beat_q == BEAT_LAST)) || errEff;
    // a first-beat retry is neither an error nor a step toward a double fault; a later-beat retry counts as an error
    assign doubleFault = (errEff || addrErr) && excStacking;
    assign grant    = !grantIn_n;
    assign pushDrop = (state_q == ST_ARB) && retried_q && curPush_q && snoopInval;

    for (genvar gi = 0; gi < WQ_DEPTH; gi++) begin : g_hit
        assign hitVec[gi] = entryLive(PTR_W'(gi), head_q, count_q) &&
            (wqAddr[gi][ADDR_W-1:LINE_LSB] == rdAddr_q[ADDR_W-1:LINE_LSB]);
    end

    // reads pass queued writes unless they collide or are serialized
    assign readGo    = rdPend_q && (hitVec == '0) &&
                       !(rdSerial_q && count_q != '0);
    assign pickRead  = (state_q == ST_IDLE) && readGo;
    assign pickWrite = (state_q == ST_IDLE) && !readGo && (count_q != '0);

    assign rdReady   = !rdPend_q;
    assign rdAccept  = rdValid && rdReady;
    assign rdFinish  = cycleDone && !curWrite_q;
    assign rdStarted = pickRead || ((state_q != ST_IDLE) && !curWrite_q);
    assign wrReady   = count_q != CNT_W'(WQ_DEPTH);
    assign wrAccept  = wrValid && wrReady;
    assign wrPop     = (cycleDone && curWrite_q) || pushDrop;

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            state_q      <= ST_IDLE;
            startPulse_q <= 1'b0;
            beat_q       <= BEAT_FIRST;
            retried_q    <= 1'b0;
        end else begin
            startPulse_q <= 1'b0;
            if (state_q != ST_HALT && doubleFault) begin
                state_q <= ST_HALT;
            end else begin
                case (state_q)
                    ST_IDLE: begin
                        if (pickRead || pickWrite) begin
                            state_q   <= ST_ARB;
                            beat_q    <= BEAT_FIRST;
                            retried_q <= 1'b0;
                        end
                    end
                    ST_ARB: begin
                        if (pushDrop) begin
                            state_q <= ST_IDLE;
                        end else if (grant) begin
                            state_q      <= ST_CYCLE;
                            startPulse_q <= 1'b1;
                            retried_q    <= 1'b0;
                        end
                    end
                    ST_CYCLE: begin
                        if (cycleDone) begin
                            state_q <= ST_IDLE;
                        end else if (rty0) begin
                            if (grant) begin
                                startPulse_q <= 1'b1;
                            end else begin
                                state_q   <= ST_ARB;
                                retried_q <= 1'b1;
                            end
                        end else if (ok) begin
                            beat_q       <= beat_q + 1'b1;
                            startPulse_q <= curBurstOff_q;
                        end
                    end
                    ST_HALT: begin
                        state_q <= ST_HALT;
                    end
                    default: begin
                        state_q <= ST_IDLE;
                    end
                endcase
            end
        end
    end

    // access information stays untouched across every retry
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            curAddr_q     <= '0;
            curData_q     <= '0;
            curWrite_q    <= 1'b0;
            curLine_q     <= 1'b0;
            curBurstOff_q <= 1'b0;
            curLock_q     <= 1'b0;
            curLast_q     <= 1'b0;
            curPush_q     <= 1'b0;
            curSerial_q   <= 1'b0;
        end else if (pickRead) begin
            curAddr_q     <= rdAddr_q;
            curWrite_q    <= 1'b0;
            curLine_q     <= rdLine_q;
            curBurstOff_q <= rdBurstOff_q;
            curLock_q     <= rdLock_q;
            curLast_q     <= 1'b0;
            curPush_q     <= 1'b0;
            curSerial_q   <= rdSerial_q;
        end else if (pickWrite) begin
            curAddr_q     <= wqAddr[head_q];
            curData_q     <= wqData[head_q];
            curWrite_q    <= 1'b1;
            curLine_q     <= 1'b0;
            curBurstOff_q <= 1'b0;
            curLock_q     <= 1'b0;
            curLast_q     <= wqLast[head_q];
            curPush_q     <= wqPush[head_q];
            curSerial_q   <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            lockOn_q <= 1'b0;
        end else if (pickRead && rdLock_q) begin
            lockOn_q <= 1'b1;
        end else if (cycleDone && curWrite_q && curLast_q) begin
            lockOn_q <= 1'b0;
        end else if (errEff && !curWrite_q && curLock_q) begin
            lockOn_q <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            rdPend_q     <= 1'b0;
            rdAddr_q     <= '0;
            rdSerial_q   <= 1'b0;
            rdLine_q     <= 1'b0;
            rdBurstOff_q <= 1'b0;
            rdLock_q     <= 1'b0;
            rdDiscard_q  <= 1'b0;
        end else if (rdAccept) begin
            rdPend_q     <= 1'b1;
            rdAddr_q     <= rdAddr;
            rdSerial_q   <= rdSerial;
            rdLine_q     <= rdLine;
            rdBurstOff_q <= rdBurstOff;
            rdLock_q     <= rdLock;
            rdDiscard_q  <= 1'b0;
        end else if (rdFinish) begin
            rdPend_q <= 1'b0;
        end else if (rdCancel && rdPend_q) begin
            if (!rdStarted) begin
                rdPend_q <= 1'b0;
            end else if (!rdSerial_q) begin
                rdDiscard_q <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            rdDone_q  <= 1'b0;
            rdFault_q <= 1'b0;
            rdData_q  <= '0;
        end else begin
            rdDone_q  <= ok && !curWrite_q && !rdDiscard_q;
            rdFault_q <= errEff && !curWrite_q && !rdDiscard_q;
            if (ok && !curWrite_q) begin
                rdData_q <= busDataIn;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (wrAccept) begin
            wqAddr[tail_q] <= wrAddr;
            wqData[tail_q] <= wrData;
            wqPush[tail_q] <= wrPush;
            wqLast[tail_q] <= wrLockLast;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            head_q  <= '0;
            tail_q  <= '0;
            count_q <= '0;
        end else begin
            if (wrAccept) begin
                tail_q <= tail_q + 1'b1;
            end
            if (wrPop) begin
                head_q <= head_q + 1'b1;
            end
            case ({wrAccept, wrPop})
                2'b10:   count_q <= count_q + 1'b1;
                2'b01:   count_q <= count_q - 1'b1;
                default: count_q <= count_q;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            wrDone_q    <= 1'b0;
            wrFault_q   <= 1'b0;
            cacheWe_q   <= 1'b0;
            cacheAddr_q <= '0;
            cacheData_q <= '0;
        end else begin
            wrDone_q    <= ok && cycleDone && curWrite_q;
            wrFault_q   <= errEff && curWrite_q;
            cacheWe_q   <= wrAccept && wrHit && cacheOn;
            cacheAddr_q <= wrAddr;
            cacheData_q <= wrData;
        end
    end

    assign rdDone    = rdDone_q;
    assign rdFault   = rdFault_q;
    assign rdData    = rdData_q;
    assign wrDone    = wrDone_q;
    assign wrFault   = wrFault_q;
    assign cacheWe   = cacheWe_q;
    assign cacheAddr = cacheAddr_q;
    assign cacheData = cacheData_q;
    assign syncStall = syncReq && (count_q != '0 || rdPend_q ||
                                   state_q != ST_IDLE);

    assign requestOut_n    = !(state_q == ST_ARB || state_q == ST_CYCLE);
    assign busOe_n         = state_q != ST_CYCLE;
    assign transferStart_n = !startPulse_q;
    assign busAddr         = curAddr_q;
    assign busWrite        = curWrite_q;
    assign busLine         = curLine_q;
    assign busDataOut      = curData_q;
    assign lockOut_n       = !lockOn_q;
    assign atomicFinalWriteFlag_n = !(curWrite_q && curLast_q &&
        (state_q == ST_ARB || state_q == ST_CYCLE));
    assign procStateCode   = (state_q == ST_HALT) ? PST_DOUBLE_FAULT : PST_RUN;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    sequence firstRetry;
        rty0 && !addrErr;
    endsequence

    sequence reissue;
        !transferStart_n && busAddr == $past(busAddr) && busWrite == $past(busWrite);
    endsequence

    sequence readPicked;
        (state_q == ST_IDLE) ##1 (state_q == ST_ARB && !curWrite_q);
    endsequence

    halt_code_a: assert property (
        state_q == ST_HALT |-> procStateCode == 4'h5 && requestOut_n && busOe_n)
        else $error("halt outputs wrong");
    halt_stays_a: assert property (
        state_q == ST_HALT |=> (state_q == ST_HALT) [*4])
        else $error("halt left without reset");
    retry_reissue_a: assert property (
        firstRetry ##0 grant |=> reissue)
        else $error("retry not reissued");
    retry_release_a: assert property (
        firstRetry ##0 !grant |=> busOe_n && !requestOut_n && transferStart_n)
        else $error("bus not released on retry");
    start_grant_a: assert property (
        !transferStart_n && beat_q == BEAT_FIRST |-> $past(grant))
        else $error("start without grant");
    late_retry_a: assert property (
        termLive && tRty && beat_q != BEAT_FIRST && !excStacking
        |=> state_q == ST_IDLE && (rdFault || wrFault || rdDiscard_q))
        else $error("late retry not aborted");
    retry_nodata_a: assert property (
        firstRetry |=> !rdDone && !wrDone && !rdFault && !wrFault)
        else $error("retry produced result");
    double_fault_a: assert property (
        termLive && tErr && excStacking |=> state_q == ST_HALT)
        else $error("double fault missed");
    plain_fault_a: assert property (
        termLive && tErr && !excStacking && !addrErr |=> state_q == ST_IDLE)
        else $error("ordinary fault halted");
    serial_wait_a: assert property (
        readPicked ##0 curSerial_q |-> $past(count_q) == '0)
        else $error("serial read passed writes");
    collide_wait_a: assert property (
        readPicked |-> $past(hitVec) == '0)
        else $error("read passed colliding write");
    read_first_a: assert property (
        state_q == ST_IDLE && readGo && count_q != '0 |=> !curWrite_q)
        else $error("write chosen over read");
    lock_hold_a: assert property (
        lockOn_q && rty0 |=> !lockOut_n)
        else $error("lock dropped on retry");
    final_hold_a: assert property (
        curWrite_q && curLast_q && rty0 && !addrErr |=> !atomicFinalWriteFlag_n)
        else $error("final write flag dropped");
    sync_stall_a: assert property (
        syncReq && count_q != '0 |-> syncStall)
        else $error("sync not stalled");
    cache_upd_a: assert property (
        wrAccept && wrHit && cacheOn |=> cacheWe && cacheAddr == $past(wrAddr))
        else $error("cache not updated");
    push_drop_a: assert property (
        pushDrop |=> state_q == ST_IDLE && transferStart_n)
        else $error("invalid push reissued");

endmodule // bus_retry_fault_ordering

`default_nettype wire

// ### verilog/term_decode.sv
// Purpose: decode of the two termination pins into one cycle outcome
// Assumes: both pins change on the same bus clock edge
// Notes:   both high means wait states, no output is raised
`default_nettype none

module term_decode (
    input  wire logic transferAck_n,
    input  wire logic transferFaultAck_n,
    output logic      termOk,
    output logic      termErr,
    output logic      termRetry
);

    assign termOk    = !transferAck_n &&  transferFaultAck_n;
    assign termErr   =  transferAck_n && !transferFaultAck_n;
    assign termRetry = !transferAck_n && !transferFaultAck_n;

endmodule // term_decode

`default_nettype wire
